// ### hw/conv_ctrl_pkg.sv
// Purpose: Shared constants for the converter control and status block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses.
package conv_ctrl_pkg;
  localparam logic [11:0] OFF_SC1       = 12'h000;
  localparam logic [11:0] OFF_SC2       = 12'h004;
  localparam logic [11:0] OFF_RES_HIGH  = 12'h008;
  localparam logic [11:0] OFF_RES_LOW   = 12'h00c;
  localparam logic [11:0] OFF_CMP_HIGH  = 12'h010;
  localparam logic [11:0] OFF_CMP_LOW   = 12'h014;
  localparam logic [11:0] OFF_CFG       = 12'h018;
  localparam int          BIT_DONE      = 7;
  localparam int          BIT_IEN       = 6;
  localparam int          BIT_CONT      = 5;
  localparam int          BIT_ACTIVE    = 7;
  localparam int          BIT_TRIG      = 6;
  localparam int          BIT_CMP_EN    = 5;
  localparam int          BIT_CMP_GE    = 4;
  localparam int          BIT_MODE10    = 0;
  localparam logic [4:0]  CHAN_OFF      = 5'h1f;
  localparam logic [7:0]  SC1_RESET     = 8'h1f;
  localparam logic [7:0]  SC2_RESET     = 8'h00;
  localparam logic [4:0]  CONV_CYCLES   = 5'h14;
endpackage : conv_ctrl_pkg

// ### hw/conv_ctrl.sv
// Purpose: Conversion control, status flags and compare for a 10-bit converter.
// Assumes: Converter core returns a 10-bit sample on CONV_DATA with CONV_DONE pulse.
// Notes:   Without a core, an internal timer ends a conversion after CONV_CYCLES.
//          The bus answers one cycle after the access edge, so every access has
//          one wait state; writes and read side effects land on the access edge.

module conv_ctrl (
  input  wire logic        CLK,        // Bus clock.
  input  wire logic        RSTN,       // Synchronous reset, active low.
  input  wire logic        PSEL,       // APB select.
  input  wire logic        PENABLE,    // APB access phase.
  input  wire logic        PWRITE,     // APB direction.
  input  wire logic [11:0] PADDR,      // APB byte address.
  input  wire logic [31:0] PWDATA,     // APB write data.
  output logic      [31:0] PRDATA,     // APB read data.
  output logic             PREADY,     // APB ready.
  output logic             PSLVERR,    // APB error on unmapped address.
  input  wire logic        HW_TRIG,    // Hardware trigger, asynchronous.
  input  wire logic        CONV_DONE,  // Core finished a sample, one cycle.
  input  wire logic [9:0]  CONV_DATA,  // Core sample.
  output logic             CONV_START, // Start pulse to the core.
  output logic             CONV_ABORT, // Abort pulse to the core.
  output logic             CONV_POWER, // Core powered.
  output logic      [4:0]  CHANNEL,    // Selected input.
  output logic             IRQ         // Conversion complete interrupt.
);

  typedef struct packed {
    // Software visible register fields.
    logic [7:0]  sc1;
    logic [7:0]  sc2;
    logic        done;
    logic [9:0]  result;
    logic [9:0]  cmp;
    logic        mode10;
    // Trigger synchroniser and conversion timer.
    logic        hold;
    logic [2:0]  trig_sync;
    logic [4:0]  timer;
    // Bus answer, valid for one cycle.
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    // Pulses and levels towards the core and the interrupt line.
    logic        start;
    logic        abort;
    logic        power;
    logic        irq;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic        acc;
  logic        wr;
  logic        rd;
  logic        trig_edge;
  logic        finish;
  logic        cmp_true;
  logic        started;
  logic [9:0]  sample;
  logic        chan_off;
  logic        keep;
  logic        sw_start;
  logic        hw_start;
  logic [31:0] rdata;

  // Bit positions, taken once from the package so the logic below stays readable.
  // The done and active bits share position 7 in their two registers.
  localparam int BIT_IEN    = conv_ctrl_pkg::BIT_IEN;
  localparam int BIT_CONT   = conv_ctrl_pkg::BIT_CONT;
  localparam int BIT_ACTIVE = conv_ctrl_pkg::BIT_ACTIVE;
  localparam int BIT_TRIG   = conv_ctrl_pkg::BIT_TRIG;
  localparam int BIT_CMP_EN = conv_ctrl_pkg::BIT_CMP_EN;
  localparam int BIT_CMP_GE = conv_ctrl_pkg::BIT_CMP_GE;
  localparam int BIT_MODE10 = conv_ctrl_pkg::BIT_MODE10;

  assign acc = PSEL && PENABLE && !st_r.pready;
  assign wr  = acc && PWRITE;
  assign rd  = acc && !PWRITE;
  assign sample = st_r.mode10 ? CONV_DATA : {2'b00, CONV_DATA[7:0]};
  // Second and third stages must agree on high after a low agreement.
  assign trig_edge = st_r.trig_sync[1] && st_r.trig_sync[2] && !st_r.hold;
  // Completion from the core, or from the internal timer as a fallback.
  assign finish = st_r.sc2[BIT_ACTIVE]
                  && (CONV_DONE || st_r.timer == conv_ctrl_pkg::CONV_CYCLES);

  // Qualifiers shared by the state update below.
  // Each is formed once here so that the set and clear paths agree on it.
  // Channel code of all ones means the converter is switched off.
  assign chan_off = st_r.sc1[4:0] == conv_ctrl_pkg::CHAN_OFF;
  // A completed sample counts when compare is off or its test holds.
  assign keep     = !st_r.sc2[BIT_CMP_EN] || cmp_true;
  // A first-register write starts under software trigger unless it switches off.
  assign sw_start = wr && PADDR == conv_ctrl_pkg::OFF_SC1 && !st_r.sc2[BIT_TRIG]
                    && PWDATA[4:0] != conv_ctrl_pkg::CHAN_OFF;
  // A trigger edge starts only when selected, idle and switched on.
  assign hw_start = trig_edge && st_r.sc2[BIT_TRIG] && !chan_off
                    && !st_r.sc2[BIT_ACTIVE];

  // Read data is formed from the registered state at the access edge.
  // Unmapped offsets read as zero; the error flag is raised elsewhere.
  // Upper bits of every 8-bit register read as zero.
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (PADDR)
      conv_ctrl_pkg::OFF_SC1: begin
        rdata[7:0] = {st_r.done, st_r.sc1[6:0]};
      end
      conv_ctrl_pkg::OFF_SC2: begin
        rdata[7:0] = {st_r.sc2[7:4], 4'h0};
      end
      conv_ctrl_pkg::OFF_RES_HIGH: begin
        rdata[1:0] = st_r.result[9:8];
      end
      conv_ctrl_pkg::OFF_RES_LOW: begin
        rdata[7:0] = st_r.result[7:0];
      end
      conv_ctrl_pkg::OFF_CMP_HIGH: begin
        rdata[1:0] = st_r.cmp[9:8];
      end
      conv_ctrl_pkg::OFF_CMP_LOW: begin
        rdata[7:0] = st_r.cmp[7:0];
      end
      conv_ctrl_pkg::OFF_CFG: begin
        rdata[0] = st_r.mode10;
      end
      default: begin
        rdata = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    // Result below compare value, or greater or equal when selected.
    if (st_r.mode10) begin
      cmp_true = st_r.sc2[BIT_CMP_GE] ? (sample >= st_r.cmp)
                                      : (sample < st_r.cmp);
    end else begin
      cmp_true = st_r.sc2[BIT_CMP_GE] ? (sample[7:0] >= st_r.cmp[7:0])
                                      : (sample[7:0] < st_r.cmp[7:0]);
    end
  end

  // Next state. Later assignments override earlier ones: a first-register write beats
  // a completion restart, and a completion that sets the done flag beats
  // any clear in the same cycle.
  always_comb begin
    st_nxt = st_r;
    started = 1'b0;
    st_nxt.start = 1'b0;
    st_nxt.abort = 1'b0;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    // Three stages deep; only the last two feed the edge test, and hold
    // keeps the level they last agreed on, so one rising change makes
    // exactly one trigger event.
    st_nxt.trig_sync = {st_r.trig_sync[1:0], HW_TRIG};
    if (st_r.trig_sync[1] == st_r.trig_sync[2]) begin
      st_nxt.hold = st_r.trig_sync[2];
    end
    // The timer ends a conversion if the core never reports one.
    if (st_r.sc2[BIT_ACTIVE]) begin
      st_nxt.timer = st_r.timer + 5'h01;
    end

    // A failed compare leaves flag and result untouched.
    if (finish) begin
      st_nxt.sc2[BIT_ACTIVE] = 1'b0;
      st_nxt.timer = 5'h00;
      if (keep) begin
        st_nxt.done = 1'b1;
        st_nxt.result = sample;
      end
      if (st_r.sc1[BIT_CONT] && !chan_off) begin
        started = 1'b1;
      end else begin
        st_nxt.power = 1'b0;
      end
    end

    // Trigger edges that arrive while converting are dropped.
    if (hw_start) begin
      started = 1'b1;
    end

    // Access edge: the write lands here and PREADY answers on the next edge.
    if (acc) begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = rdata;
      unique case (PADDR)
        conv_ctrl_pkg::OFF_SC1: begin
          if (wr) begin
            // Done bit position is not stored from write data.
            st_nxt.sc1 = {1'b0, PWDATA[6:0]};
            st_nxt.done = 1'b0;
            // Any write ends a running conversion before a new one starts.
            st_nxt.abort = st_r.sc2[BIT_ACTIVE];
            st_nxt.sc2[BIT_ACTIVE] = 1'b0;
            st_nxt.timer = 5'h00;
            started = sw_start;
            if (PWDATA[4:0] == conv_ctrl_pkg::CHAN_OFF) begin
              st_nxt.power = 1'b0;
            end
          end
        end
        conv_ctrl_pkg::OFF_SC2: begin
          if (wr) begin
            // Active bit is status only; reserved bits store nothing.
            st_nxt.sc2[6:4] = PWDATA[6:4];
          end
        end
        conv_ctrl_pkg::OFF_RES_HIGH: begin
          st_nxt.pslverr = 1'b0;
        end
        conv_ctrl_pkg::OFF_RES_LOW: begin
          if (rd) begin
            st_nxt.done = 1'b0;
          end
        end
        conv_ctrl_pkg::OFF_CMP_HIGH: begin
          if (wr) begin
            st_nxt.cmp[9:8] = PWDATA[1:0];
          end
        end
        conv_ctrl_pkg::OFF_CMP_LOW: begin
          if (wr) begin
            st_nxt.cmp[7:0] = PWDATA[7:0];
          end
        end
        conv_ctrl_pkg::OFF_CFG: begin
          if (wr) begin
            st_nxt.mode10 = PWDATA[BIT_MODE10];
          end
        end
        default: begin
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end

    // A completion in the same cycle as the clear still counts.
    if (finish && keep) begin
      st_nxt.done = 1'b1;
    end

    if (started) begin
      st_nxt.start = 1'b1;
      st_nxt.power = 1'b1;
      st_nxt.sc2[BIT_ACTIVE] = 1'b1;
      st_nxt.timer = 5'h00;
    end

    // The request is a level that follows the flag and its enable.
    st_nxt.irq = st_nxt.done && st_nxt.sc1[BIT_IEN];
  end

  // Synchronous reset; the channel field comes up switched off.
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st_r <= '0;
      st_r.sc1 <= conv_ctrl_pkg::SC1_RESET;
      st_r.sc2 <= conv_ctrl_pkg::SC2_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output is a bit of the registered state.
  assign PRDATA     = st_r.prdata;
  assign PREADY     = st_r.pready;
  assign PSLVERR    = st_r.pslverr;
  assign CONV_START = st_r.start;
  assign CONV_ABORT = st_r.abort;
  assign CONV_POWER = st_r.power;
  assign CHANNEL    = st_r.sc1[4:0];
  assign IRQ        = st_r.irq;

endmodule : conv_ctrl

// ### verification/conv_ctrl_chk.sv
// Purpose: Port checker for conv_ctrl.
// Assumes: A write takes effect at its access edge.
// Notes:   Shadows the trigger select bit from bus writes.
module conv_ctrl_chk (
  input wire logic        CLK,        // Clock.
  input wire logic        RSTN,       // Reset.
  input wire logic        PSEL,       // Select.
  input wire logic        PENABLE,    // Enable.
  input wire logic        PWRITE,     // Write.
  input wire logic [11:0] PADDR,      // Address.
  input wire logic [31:0] PWDATA,     // Data.
  input wire logic        PREADY,     // Ready.
  input wire logic        PSLVERR,    // Error.
  input wire logic        CONV_DONE,  // Done.
  input wire logic        CONV_START, // Start.
  input wire logic        CONV_POWER, // Power.
  input wire logic [4:0]  CHANNEL,    // Channel.
  input wire logic        IRQ         // Irq.
);
  logic acc;
  logic trig_r;
  assign acc = PSEL && PENABLE && !PREADY;
  always_ff @(posedge CLK) begin
    if (!RSTN)
      trig_r <= 1'b0;
    else if (acc && PWRITE && PADDR == conv_ctrl_pkg::OFF_SC2)
      trig_r <= PWDATA[6];
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_wr1; acc && PWRITE && PADDR == conv_ctrl_pkg::OFF_SC1; endsequence
  sequence s_off; s_wr1 ##0 PWDATA[4:0] == conv_ctrl_pkg::CHAN_OFF; endsequence
  property p_rdy; acc |=> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_one; PREADY |=> !PREADY; endproperty
  a_one: assert property (p_one) else $error("ready held");
  property p_err; PREADY |-> PSLVERR == (PADDR > conv_ctrl_pkg::OFF_CFG); endproperty
  a_err: assert property (p_err) else $error("bad error flag");
  property p_chan; s_wr1 |=> CHANNEL == $past(PWDATA[4:0]); endproperty
  a_chan: assert property (p_chan) else $error("channel wrong");
  property p_off; s_off |=> !CONV_START [*3]; endproperty
  a_off: assert property (p_off) else $error("start when off");
  property p_pwr; s_off |-> ##[1:2] !CONV_POWER; endproperty
  a_pwr: assert property (p_pwr) else $error("power kept");
  property p_sw; s_wr1 ##0 (PWDATA[4:0] != 5'h1f && !trig_r) |=> CONV_START; endproperty
  a_sw: assert property (p_sw) else $error("no start");
  property p_hw; s_wr1 ##0 trig_r |=> !CONV_START; endproperty
  a_hw: assert property (p_hw) else $error("start on write");
  property p_clr; s_wr1 ##0 !CONV_DONE |=> !IRQ; endproperty
  a_clr: assert property (p_clr) else $error("irq kept");
endmodule : conv_ctrl_chk

bind conv_ctrl conv_ctrl_chk u_chk (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CONV_DONE(CONV_DONE), .CONV_START(CONV_START), .CONV_POWER(CONV_POWER),
  .CHANNEL(CHANNEL), .IRQ(IRQ));

// ### verification/tb.sv
// Purpose: Register level tests of conv_ctrl.
// Assumes: Core done pulses are driven by the bench.
// Notes:   Start and abort pulses are counted.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, RSTN, PSEL, PENABLE, PWRITE, HW_TRIG, CONV_DONE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic        PREADY, PSLVERR, CONV_START, CONV_ABORT, CONV_POWER, IRQ;
  logic [9:0]  CONV_DATA;
  logic [4:0]  CHANNEL;
  int          failures = 0, n_tests = 0, starts = 0, aborts = 0, s;
  conv_ctrl u_dut (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .HW_TRIG(HW_TRIG), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA),
    .CONV_START(CONV_START), .CONV_ABORT(CONV_ABORT), .CONV_POWER(CONV_POWER),
    .CHANNEL(CHANNEL), .IRQ(IRQ));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    if (RSTN === 1'b1) begin
      starts <= starts + int'(CONV_START);
      aborts <= aborts + int'(CONV_ABORT);
    end
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task rw(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
    {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    if (!w) chk("rdata", PRDATA, exp);
    chk("slverr", {31'h0, PSLVERR}, {31'h0, a > conv_ctrl_pkg::OFF_CFG});
    {PSEL, PENABLE} <= 2'b00;
    @(posedge CLK);
  endtask : rw
  task done(input logic [9:0] v);
    {CONV_DONE, CONV_DATA} <= {1'b1, v};
    @(posedge CLK);
    CONV_DONE <= 1'b0;
    @(posedge CLK);
  endtask : done
  task cmpc(input logic [31:0] sc2, input logic [9:0] v, input logic [31:0] exp);
    rw(1, conv_ctrl_pkg::OFF_SC2, sc2, 0);
    rw(1, conv_ctrl_pkg::OFF_SC1, 32'h03, 0);
    done(v);
    rw(0, conv_ctrl_pkg::OFF_SC1, 0, exp);
    chk("irq", {31'h0, IRQ}, 0);
  endtask : cmpc
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    repeat (5000) @(posedge CLK);
    failures++;
    end_sim;
  end
  initial begin
    {RSTN, PSEL, PENABLE, PWRITE, HW_TRIG, CONV_DONE} = 6'h00;
    {PADDR, PWDATA, CONV_DATA} = 54'h0;
    repeat (16) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    rw(0, conv_ctrl_pkg::OFF_SC1, 0, 32'h1f);
    rw(0, conv_ctrl_pkg::OFF_SC2, 0, 32'h00);
    rw(0, 12'h040, 0, 0);
    $display("test reset end");
    rw(1, conv_ctrl_pkg::OFF_CFG, 32'h1, 0);
    rw(1, conv_ctrl_pkg::OFF_SC1, 32'hc3, 0);
    chk("chan", {27'h0, CHANNEL}, 32'h3);
    rw(0, conv_ctrl_pkg::OFF_SC1, 0, 32'h43);
    rw(0, conv_ctrl_pkg::OFF_SC2, 0, 32'h80);
    rw(1, conv_ctrl_pkg::OFF_SC1, 32'h43, 0);
    chk("aborts", aborts, 1);
    chk("starts", starts, 2);
    done(10'h2a5);
    rw(0, conv_ctrl_pkg::OFF_SC2, 0, 32'h00);
    rw(0, conv_ctrl_pkg::OFF_SC1, 0, 32'hc3);
    chk("irq", {31'h0, IRQ}, 1);
    rw(0, conv_ctrl_pkg::OFF_RES_HIGH, 0, 32'h2);
    rw(0, conv_ctrl_pkg::OFF_RES_LOW, 0, 32'ha5);
    rw(0, conv_ctrl_pkg::OFF_SC1, 0, 32'h43);
    chk("irq", {31'h0, IRQ}, 0);
    chk("starts", starts, 2);
    chk("power", {31'h0, CONV_POWER}, 0);
    $display("test software start end");
    rw(1, conv_ctrl_pkg::OFF_CMP_LOW, 32'h10, 0);
    cmpc(32'h20, 10'h050, 32'h03);
    rw(0, conv_ctrl_pkg::OFF_RES_LOW, 0, 32'ha5);
    cmpc(32'h20, 10'h005, 32'h83);
    cmpc(32'h30, 10'h050, 32'h83);
    cmpc(32'h30, 10'h005, 32'h03);
    rw(1, conv_ctrl_pkg::OFF_CFG, 32'h0, 0);
    rw(1, conv_ctrl_pkg::OFF_CMP_HIGH, 32'h3, 0);
    cmpc(32'h30, 10'h050, 32'h83);
    rw(0, conv_ctrl_pkg::OFF_RES_HIGH, 0, 32'h0);
    $display("test compare end");
    rw(1, conv_ctrl_pkg::OFF_SC2, 32'h00, 0);
    s = starts;
    rw(1, conv_ctrl_pkg::OFF_SC1, 32'h22, 0);
    done(10'h001);
    repeat (4) @(posedge CLK);
    chk("starts", starts, s + 2);
    rw(1, conv_ctrl_pkg::OFF_SC1, 32'h3f, 0);
    repeat (30) @(posedge CLK);
    chk("starts", starts, s + 2);
    chk("power", {31'h0, CONV_POWER}, 0);
    $display("test continuous end");
    rw(1, conv_ctrl_pkg::OFF_SC2, 32'h40, 0);
    s = starts;
    rw(1, conv_ctrl_pkg::OFF_SC1, 32'h01, 0);
    chk("starts", starts, s);
    HW_TRIG <= 1'b1;
    repeat (8) @(posedge CLK);
    chk("starts", starts, s + 1);
    done(10'h000);
    HW_TRIG <= 1'b0;
    repeat (10) @(posedge CLK);
    chk("starts", starts, s + 1);
    $display("test hardware trigger end");
    end_sim;
  end
endmodule : tb
